// File: hdl/cot_output_timing.sv
// Output timing control of the front-end converter
`timescale 1ns/100ps
module cot_output_timing
   import cot_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              conversion_clock,
   input  wire logic              output_clock,
   input  wire logic              serial_clock,
   input  wire logic              serial_select_n,
   input  wire logic              serial_data_in,
   input  wire logic              reset_level_sample_pulse,
   input  wire logic              data_level_sample_pulse,
   input  wire logic [COT_DW-1:0] adc_code,
   output      logic [COT_DW-1:0] pixel_data,
   output      logic              reset_pulse_int,
   output      logic              data_pulse_int,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr
);
   localparam int NIN = 7 + COT_DW;

   function automatic logic edge_up(input logic now_v, input logic was_v);
      return now_v & ~was_v;
   endfunction : edge_up

   // Two-stage synchronisers for every pin input except clk_sys, sys_rst and the APB bus
   logic [NIN-1:0]    in_meta;
   logic [NIN-1:0]    in_sync;
   logic              conv_prev;
   logic              oclk_prev;
   logic              output_clock_select_bit;
   logic              conv_clock_polarity_bit;
   logic              input_path_bit;
   logic              amplifier_input_bit;
   logic              sample_pulse_invert_bit;
   logic [15:0]       last_word;
   logic [COT_DW-1:0] captured;
   logic [COT_AW-1:0] wr_ptr;
   logic [COT_DW-1:0] mem_rdata;
   logic              mem_primed;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         in_meta <= '0;
         in_sync <= '0;
      end else begin
         in_meta <= {conversion_clock, output_clock, serial_clock, serial_select_n,
                     serial_data_in, reset_level_sample_pulse, data_level_sample_pulse,
                     adc_code};
         in_sync <= in_meta;
      end
   end

   wire                conv_s  = in_sync[NIN-1];
   wire                oclk_s  = in_sync[NIN-2];
   wire                shr_s   = in_sync[COT_DW+1];
   wire                shd_s   = in_sync[COT_DW];
   wire [COT_DW-1:0]   adc_s   = in_sync[COT_DW-1:0];
   wire                conv_rise = edge_up(conv_s, conv_prev);
   wire                conv_fall = edge_up(conv_prev, conv_s);
   wire                oclk_rise = edge_up(oclk_s, oclk_prev);
   wire                conv_edge = conv_rise | conv_fall;

   cot_ser_if ser ();
   assign ser.sck   = in_sync[NIN-3];
   assign ser.sel_n = in_sync[NIN-4];
   assign ser.sdi   = in_sync[NIN-5];

   cot_serial_rx u_rx (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .ser     (ser)
   );

   // Mode decode
   wire       direct_mode = input_path_bit;
   wire       pol_eff     = conv_clock_polarity_bit & direct_mode;
   wire       amp_mode    = ~input_path_bit & amplifier_input_bit;
   wire [4:0] lat_base    = pol_eff ? COT_LAT_INV : COT_LAT_NORM;
   wire [4:0] lat         = amp_mode ? 5'(lat_base + COT_LAT_AMP) : lat_base;
   wire       out_clk_rise = output_clock_select_bit ? oclk_rise : conv_rise;
   wire       out_evt     = pol_eff ? conv_fall : out_clk_rise;
   wire [COT_DW-1:0] wr_data = conv_fall ? adc_s : captured;
   // Read one write early: the memory read register adds the missing cycle
   wire [COT_AW-1:0] rd_addr = wr_ptr - lat;

   cot_delay_mem u_mem (
      .clk_sys (clk_sys),
      .we      (conv_edge),
      .waddr   (wr_ptr),
      .wdata   (wr_data),
      .raddr   (rd_addr),
      .rdata   (mem_rdata)
   );

   // Pipeline advanced on every conversion clock half period
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         conv_prev  <= 1'b0;
         oclk_prev  <= 1'b0;
         captured   <= '0;
         wr_ptr     <= '0;
         pixel_data <= '0;
         mem_primed <= 1'b0;
      end else begin
         conv_prev <= conv_s;
         oclk_prev <= oclk_s;
         if (conv_fall)
            captured <= adc_s;
         if (conv_edge)
            wr_ptr <= wr_ptr + 5'h01;
         // Entries stay unknown until every address has been written once
         if (conv_edge && wr_ptr == '1)
            mem_primed <= 1'b1;
         if (out_evt)
            pixel_data <= mem_primed ? mem_rdata : '0;
      end
   end

   // Sample pulse inversion is a plain XOR, so all polarity pairings stay legal
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reset_pulse_int <= 1'b0;
         data_pulse_int  <= 1'b0;
      end else begin
         reset_pulse_int <= shr_s ^ sample_pulse_invert_bit;
         data_pulse_int  <= shd_s ^ sample_pulse_invert_bit;
      end
   end

   // APB slave; serial loads win over a bus write in the same cycle
   wire       apb_acc = psel & penable & ~pready;
   // Writes land at the edge at which the master sees pready high, not a cycle earlier
   wire       apb_wr  = psel & penable & pready & pwrite;
   wire       hit_m1  = (paddr == COT_OFS_MODE1);
   wire       hit_m2  = (paddr == COT_OFS_MODE2);
   wire       hit_wd  = (paddr == COT_OFS_WORD);
   wire       hit_dt  = (paddr == COT_OFS_DATA);
   wire       mapped  = hit_m1 | hit_m2 | hit_wd | hit_dt;
   wire [3:0] ser_sel = ser.word[COT_SEL_HI:COT_SEL_LO];
   wire       ser_m1  = ser.word_stb & (ser_sel == COT_SEL_MODE1);
   wire       ser_m2  = ser.word_stb & (ser_sel == COT_SEL_MODE2);
   wire [8:0] m1_src  = ser_m1 ? ser.word[8:0] : pwdata[8:0];
   wire       ld_m1   = ser_m1 | (apb_wr & hit_m1);
   wire       ld_m2   = ser_m2 | (apb_wr & hit_m2);
   wire       inv_src = ser_m2 ? ser.word[COT_B_INV] : pwdata[COT_B_INV];
   wire [31:0] mode1_rd = {23'h0, output_clock_select_bit, 1'b0, conv_clock_polarity_bit,
                           input_path_bit, amplifier_input_bit, 4'h0};
   wire [31:0] rd_mux = hit_m1 ? mode1_rd :
                        hit_m2 ? {29'h0, sample_pulse_invert_bit, 2'h0} :
                        hit_wd ? {16'h0, last_word} :
                        hit_dt ? {22'h0, pixel_data} : 32'h0;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         output_clock_select_bit <= COT_RST_OUTSEL;
         conv_clock_polarity_bit <= COT_RST_POL;
         input_path_bit          <= COT_RST_PATH;
         amplifier_input_bit     <= COT_RST_AMP;
         sample_pulse_invert_bit <= COT_RST_INV;
      end else begin
         if (ld_m1) begin
            output_clock_select_bit <= m1_src[COT_B_OUTSEL];
            conv_clock_polarity_bit <= m1_src[COT_B_POL];
            input_path_bit          <= m1_src[COT_B_PATH];
            amplifier_input_bit     <= m1_src[COT_B_AMP];
         end
         if (ld_m2)
            sample_pulse_invert_bit <= inv_src;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         last_word <= '0;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         prdata    <= '0;
      end else begin
         if (ser.word_stb)
            last_word <= ser.word;
         pready  <= apb_acc;
         pslverr <= apb_acc & ~mapped;
         prdata  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0;
      end
   end

   sequence s_out_evt_ext;
      mem_primed && output_clock_select_bit && !pol_eff && oclk_rise;
   endsequence

   property p_outsel_ext;
      @(posedge clk_sys) disable iff (sys_rst)
      s_out_evt_ext |=> pixel_data == $past(mem_rdata);
   endproperty
   a_outsel_ext: assert property (p_outsel_ext) else $error("no output on output clock");

   property p_outsel_conv;
      @(posedge clk_sys) disable iff (sys_rst)
      ($changed(pixel_data) && !$past(output_clock_select_bit) && !$past(pol_eff))
         |-> $past(conv_rise);
   endproperty
   a_outsel_conv: assert property (p_outsel_conv) else $error("output off conv rise");

   property p_sample_fall;
      @(posedge clk_sys) disable iff (sys_rst)
      conv_fall |=> captured == $past(adc_s);
   endproperty
   a_sample_fall: assert property (p_sample_fall) else $error("sample not on fall");

   property p_inv_out;
      @(posedge clk_sys) disable iff (sys_rst)
      (mem_primed && pol_eff && conv_fall) |=> pixel_data == $past(mem_rdata);
   endproperty
   a_inv_out: assert property (p_inv_out) else $error("inverted output missed");

   property p_lat_norm;
      @(posedge clk_sys) disable iff (sys_rst)
      (direct_mode && !conv_clock_polarity_bit) |-> wr_ptr - rd_addr == 5'h0b;
   endproperty
   a_lat_norm: assert property (p_lat_norm) else $error("normal latency wrong");

   property p_lat_inv;
      @(posedge clk_sys) disable iff (sys_rst)
      (direct_mode && conv_clock_polarity_bit) |-> wr_ptr - rd_addr == 5'h0c;
   endproperty
   a_lat_inv: assert property (p_lat_inv) else $error("inverted latency wrong");

   property p_pol_direct;
      @(posedge clk_sys) disable iff (sys_rst)
      (!input_path_bit && amplifier_input_bit) |-> !pol_eff && wr_ptr - rd_addr == 5'h0f;
   endproperty
   a_pol_direct: assert property (p_pol_direct) else $error("amp path latency");

   property p_pulse_inv;
      @(posedge clk_sys) disable iff (sys_rst)
      ##1 (reset_pulse_int == ($past(shr_s) ^ $past(sample_pulse_invert_bit)))
         && (data_pulse_int == ($past(shd_s) ^ $past(sample_pulse_invert_bit)));
   endproperty
   a_pulse_inv: assert property (p_pulse_inv) else $error("pulse inversion wrong");

   property p_rst_dflt;
      @(posedge clk_sys)
      sys_rst |=> !conv_clock_polarity_bit && !sample_pulse_invert_bit;
   endproperty
   a_rst_dflt: assert property (p_rst_dflt) else $error("reset defaults wrong");

   // Glitch guard: the data pins may only move on the selected output edge
   property p_pix_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      !$past(out_evt) |-> $stable(pixel_data);
   endproperty
   a_pix_hold: assert property (p_pix_hold) else $error("output off edge");

   property p_inv_no_rise;
      @(posedge clk_sys) disable iff (sys_rst)
      (pol_eff && conv_rise) |=> $stable(pixel_data);
   endproperty
   a_inv_no_rise: assert property (p_inv_no_rise) else $error("rise moved output");

   property p_amp_fall;
      @(posedge clk_sys) disable iff (sys_rst)
      (amp_mode && !output_clock_select_bit && conv_fall) |=> $stable(pixel_data);
   endproperty
   a_amp_fall: assert property (p_amp_fall) else $error("amp fall output");

   property p_sample_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      !conv_fall |=> $stable(captured);
   endproperty
   a_sample_hold: assert property (p_sample_hold) else $error("sample moved");

   property p_ser_mode1;
      @(posedge clk_sys) disable iff (sys_rst)
      ser_m1 |=> input_path_bit == $past(ser.word[COT_B_PATH])
                 && output_clock_select_bit == $past(ser.word[COT_B_OUTSEL]);
   endproperty
   a_ser_mode1: assert property (p_ser_mode1) else $error("serial load lost");

   property p_mode_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      (!ld_m1 && !ld_m2)
         |=> $stable(conv_clock_polarity_bit) && $stable(sample_pulse_invert_bit);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode bits moved");
endmodule : cot_output_timing

// File: hdl/cot_pkg.sv
// Constants shared by the output timing block
package cot_pkg;
   localparam int          COT_DW           = 10;
   localparam int          COT_AW           = 5;
   localparam int          COT_WORD_BITS    = 16;
   // Latency in conversion-clock half periods
   localparam logic [4:0]  COT_LAT_NORM     = 5'h0b;
   localparam logic [4:0]  COT_LAT_INV      = 5'h0c;
   localparam logic [4:0]  COT_LAT_AMP      = 5'h04;
   // Serial word layout
   localparam int          COT_SEL_HI       = 15;
   localparam int          COT_SEL_LO       = 12;
   localparam logic [3:0]  COT_SEL_MODE1    = 4'h1;
   localparam logic [3:0]  COT_SEL_MODE2    = 4'h2;
   localparam int          COT_B_OUTSEL     = 8;
   localparam int          COT_B_POL        = 6;
   localparam int          COT_B_PATH       = 5;
   localparam int          COT_B_AMP        = 4;
   localparam int          COT_B_INV        = 2;
   // Reset values
   localparam logic        COT_RST_OUTSEL   = 1'b0;
   localparam logic        COT_RST_POL      = 1'b0;
   localparam logic        COT_RST_PATH     = 1'b1;
   localparam logic        COT_RST_AMP      = 1'b0;
   localparam logic        COT_RST_INV      = 1'b0;
   // APB offsets and the serial bit counter limit
   localparam logic [7:0]  COT_OFS_MODE1    = 8'h00;
   localparam logic [7:0]  COT_OFS_MODE2    = 8'h04;
   localparam logic [7:0]  COT_OFS_WORD     = 8'h08;
   localparam logic [7:0]  COT_OFS_DATA     = 8'h0c;
   localparam logic [4:0]  COT_BITCNT_MAX   = 5'h11;
endpackage : cot_pkg

// File: hdl/cot_ser_if.sv
// Carrier between the core and the serial control receiver
`timescale 1ns/100ps
interface cot_ser_if;
   logic        sck;
   logic        sel_n;
   logic        sdi;
   logic        word_stb;
   logic [15:0] word;
   modport rx   (input sck, input sel_n, input sdi, output word_stb, output word);
   modport core (output sck, output sel_n, output sdi, input word_stb, input word);
endinterface : cot_ser_if

// File: hdl/cot_serial_rx.sv
// Serial control word receiver, 16 bits framed by the select
`timescale 1ns/100ps
module cot_serial_rx
   import cot_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   cot_ser_if.rx     ser
);
   logic [4:0]  bit_cnt;
   logic [15:0] shift;
   logic        sck_prev;
   logic        sel_prev;
   wire         sck_rise = ser.sck & ~sck_prev;
   wire         frame_end = ser.sel_n & ~sel_prev;
   wire         full = (bit_cnt == 5'(COT_WORD_BITS));

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bit_cnt  <= '0;
         shift    <= '0;
         sck_prev <= 1'b0;
         sel_prev <= 1'b1;
         ser.word_stb <= 1'b0;
         ser.word <= '0;
      end else begin
         sck_prev <= ser.sck;
         sel_prev <= ser.sel_n;
         ser.word_stb <= frame_end & full;
         if (frame_end && full)
            ser.word <= shift;
         if (ser.sel_n)
            bit_cnt <= '0;
         else if (sck_rise) begin
            shift <= {shift[14:0], ser.sdi};
            if (bit_cnt != COT_BITCNT_MAX)
               bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   property p_word_len;
      @(posedge clk_sys) disable iff (sys_rst)
      ser.word_stb |-> $past(bit_cnt) == 5'h10 && $past(ser.sel_n, 2) == 1'b0;
   endproperty
   a_word_len: assert property (p_word_len) else $error("word not 16 bits");
endmodule : cot_serial_rx

// File: hdl/cot_delay_mem.sv
// Sample delay memory with registered read data
`timescale 1ns/100ps
module cot_delay_mem
   import cot_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              we,
   input  wire logic [COT_AW-1:0] waddr,
   input  wire logic [COT_DW-1:0] wdata,
   input  wire logic [COT_AW-1:0] raddr,
   output      logic [COT_DW-1:0] rdata
);
   logic [COT_DW-1:0] mem [0:(1<<COT_AW)-1];

   always_ff @(posedge clk_sys) begin
      if (we)
         mem[waddr] <= wdata;
      rdata <= mem[raddr];
   end
endmodule : cot_delay_mem

// File: dv/cot_isp_model.sv
// Image processor model: conversion clock, codes, output clock, serial words
`timescale 1ns/100ps
module cot_isp_model
   import cot_pkg::*;
(
   input  wire logic              oc_hold,
   output      logic              conversion_clock,
   output      logic              output_clock,
   output      logic [COT_DW-1:0] adc_code,
   output      logic              serial_clock,
   output      logic              serial_select_n,
   output      logic              serial_data_in
);
   logic [COT_DW-1:0] hist [int];
   int                h;

   // Held low on request, so outputs timed from it must stall
   assign #20 output_clock = ~oc_hold & conversion_clock;

   initial begin
      h = 0;
      conversion_clock = 1'b0;
      adc_code = '0;
      serial_clock = 1'b0;
      serial_select_n = 1'b1;
      serial_data_in = 1'b0;
      forever begin
         #80 conversion_clock = ~conversion_clock;
         h++;
         // Code moves half a period away from the sampling fall
         if (conversion_clock)
            adc_code = COT_DW'($urandom);
         else
            hist[h] = adc_code;
      end
   end

   task automatic send_word(input logic [15:0] w, input int n);
      // Step off the system clock edge so no pin moves where it is sampled
      #3;
      serial_select_n = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         serial_data_in = w[i];
         #40 serial_clock = 1'b1;
         #40 serial_clock = 1'b0;
      end
      #40 serial_select_n = 1'b1;
      // Released line must not keep showing the last bit
      serial_data_in = ~serial_data_in;
   endtask : send_word
endmodule : cot_isp_model

// File: dv/cot_output_timing_tb_top.sv
// Self-checking bench of the output timing block
`timescale 1ns/100ps
module cot_output_timing_tb_top
   import cot_pkg::*;
;
   logic              clk_sys;
   logic              sys_rst;
   logic              oc_hold;
   logic              conversion_clock;
   logic              output_clock;
   logic              serial_clock;
   logic              serial_select_n;
   logic              serial_data_in;
   logic              reset_level_sample_pulse;
   logic              data_level_sample_pulse;
   logic [COT_DW-1:0] adc_code;
   logic [COT_DW-1:0] pixel_data;
   logic              reset_pulse_int;
   logic              data_pulse_int;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [7:0]        paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [15:0]       w;
   logic [9:0]        p0;
   int                n_mismatch;
   int                checked;
   // Mode table {polarity, path, amplifier} and latency in half periods
   localparam logic [2:0] PM [5] = '{3'b010, 3'b110, 3'b101, 3'b000, 3'b100};
   localparam int         PL [5] = '{11, 12, 15, 11, 11};

   cot_output_timing u_cot_output_timing (.clk_sys, .sys_rst, .conversion_clock,
      .output_clock, .serial_clock, .serial_select_n, .serial_data_in,
      .reset_level_sample_pulse, .data_level_sample_pulse, .adc_code, .pixel_data,
      .reset_pulse_int, .data_pulse_int, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);

   cot_isp_model u_cot_isp_model (.oc_hold, .conversion_clock, .output_clock, .adc_code,
      .serial_clock, .serial_select_n, .serial_data_in);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] mode1(input logic s, input logic [2:0] m);
      return (32'(s) << COT_B_OUTSEL) | (32'(m[2]) << COT_B_POL)
           | (32'(m[1]) << COT_B_PATH) | (32'(m[0]) << COT_B_AMP);
   endfunction : mode1

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'b1, a, d, rd, e);
   endtask : wr

   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
      logic [31:0] d;
      logic        e;
      apb(1'b0, a, 32'h0, d, e);
      chk(n, d, x);
      chk({n, " err"}, 32'(e), 32'(xe));
   endtask : rdc

   // Sample just before the next conversion edge, once the output has moved
   task automatic pix(input int lat);
      repeat (12) @(posedge conversion_clock);
      repeat (10) begin
         if (lat == 12)
            @(negedge conversion_clock);
         else
            @(posedge conversion_clock);
         #70 chk("pixel_data", 32'(pixel_data),
                 32'(u_cot_isp_model.hist[u_cot_isp_model.h - lat]));
      end
   endtask : pix

   initial begin
      #200000;
      n_mismatch++;
      stop_test();
   end

   initial begin
      void'($urandom(14963));
      n_mismatch = 0;
      checked = 0;
      sys_rst = 1'b1;
      oc_hold = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      reset_level_sample_pulse = 1'b1;
      data_level_sample_pulse = 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("reset pixel", 32'(pixel_data), 32'h0);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk("default pulse", 32'(reset_pulse_int), 32'h1);
      rdc("mode1", COT_OFS_MODE1, mode1(COT_RST_OUTSEL, {COT_RST_POL, COT_RST_PATH,
          COT_RST_AMP}), 1'b0);
      rdc("mode2", COT_OFS_MODE2, 32'h0, 1'b0);
      rdc("unmapped", 8'h10, 32'h0, 1'b1);
      for (int k = 0; k < 4; k++) begin
         wr(COT_OFS_MODE1, mode1(1'b0, {k[0], 2'b10}));
         wr(COT_OFS_MODE2, 32'(k[1]) << COT_B_INV);
         repeat (3) begin
            reset_level_sample_pulse <= 1'($urandom);
            data_level_sample_pulse <= 1'($urandom);
            repeat (6) @(posedge clk_sys);
            chk("reset pulse", 32'(reset_pulse_int), 32'(reset_level_sample_pulse ^ k[1]));
            chk("data pulse", 32'(data_pulse_int), 32'(data_level_sample_pulse ^ k[1]));
         end
      end
      for (int k = 0; k < 5; k++) begin
         wr(COT_OFS_MODE1, mode1(1'b0, PM[k]));
         pix(PL[k]);
      end
      wr(COT_OFS_MODE1, mode1(1'b1, 3'b010));
      repeat (12) @(posedge conversion_clock);
      p0 = pixel_data;
      repeat (10) begin
         @(posedge conversion_clock);
         chk("held output", 32'(pixel_data), 32'(p0));
      end
      rdc("data reg", COT_OFS_DATA, 32'(p0), 1'b0);
      @(posedge clk_sys);
      oc_hold <= 1'b0;
      repeat (4) @(posedge conversion_clock);
      chk("output moves", 32'(pixel_data !== p0), 32'h1);
      #70 chk("ext clock pixel", 32'(pixel_data),
              32'(u_cot_isp_model.hist[u_cot_isp_model.h - 11]));
      w = {COT_SEL_MODE1, 12'($urandom)};
      u_cot_isp_model.send_word(w, 16);
      repeat (10) @(posedge clk_sys);
      rdc("serial mode1", COT_OFS_MODE1, 32'(w) & 32'h170, 1'b0);
      rdc("word", COT_OFS_WORD, 32'(w), 1'b0);
      u_cot_isp_model.send_word({COT_SEL_MODE2, 12'hfff}, 15);
      repeat (10) @(posedge clk_sys);
      rdc("short frame", COT_OFS_WORD, 32'(w), 1'b0);
      w = {COT_SEL_MODE2, 12'($urandom)};
      u_cot_isp_model.send_word(w, 16);
      repeat (10) @(posedge clk_sys);
      rdc("serial mode2", COT_OFS_MODE2, 32'(w) & 32'h4, 1'b0);
      stop_test();
   end
endmodule : cot_output_timing_tb_top
